//--- rtl/upr_router.sv
// usb port ownership router: four downstream ports shared between two
// full-speed host cores and one high-speed host core
// assumes all cores and transceivers run on mclk_in; the hs core holds the
// route enable and four release bits and presents their writes as strobes
//
// How it works
// - ports 1,3 to fs core 0; 2,4 core 1
// - hs core bits decide each port's owner
// - reset gives every port to fs cores
// - fs writes ignored on hs owned ports
// - hs only port bits hidden from fs
// - fs owned port runs 12 or 1.5 Mbit/s
// - hs owned port runs 480 Mbit/s
`timescale 1ns/1ps
`default_nettype none
module upr_router #(
  parameter int PORTS = upr_pkg::PORTS,
  parameter int LANES = upr_pkg::LANES,
  parameter int W     = upr_pkg::PREG_W,
  parameter int L     = upr_pkg::LINE_W
) (
  input  wire logic                      mclk_in,
  input  wire logic                      rst_n_in,
  // ownership bits written by the hs core (global route enable, per port
  // release back to the fs cores)
  input  wire logic                      hs_route_wr_in,
  input  wire logic                      hs_route_in,
  input  wire logic [PORTS-1:0]          hs_release_wr_in,
  input  wire logic [PORTS-1:0]          hs_release_in,
  // hs core port register and line access, indexed by physical port
  input  wire logic [PORTS-1:0]          hs_wr_in,
  input  wire logic [W-1:0]              hs_wdata_in,
  input  wire logic [PORTS-1:0]          hs_tx_en_in,
  input  wire logic [PORTS-1:0][L-1:0]   hs_tx_dat_in,
  output logic      [PORTS-1:0][W-1:0]   hs_rdata_out,
  output logic      [PORTS-1:0][L-1:0]   hs_rx_out,
  // fs core 0, lane 0 is port 1 and lane 1 is port 3
  input  wire logic [LANES-1:0]          fs0_wr_in,
  input  wire logic [W-1:0]              fs0_wdata_in,
  input  wire logic [LANES-1:0]          fs0_ls_in,
  input  wire logic [LANES-1:0]          fs0_tx_en_in,
  input  wire logic [LANES-1:0][L-1:0]   fs0_tx_dat_in,
  output logic      [LANES-1:0][W-1:0]   fs0_rdata_out,
  output logic      [LANES-1:0][L-1:0]   fs0_rx_out,
  // fs core 1, lane 0 is port 2 and lane 1 is port 4
  input  wire logic [LANES-1:0]          fs1_wr_in,
  input  wire logic [W-1:0]              fs1_wdata_in,
  input  wire logic [LANES-1:0]          fs1_ls_in,
  input  wire logic [LANES-1:0]          fs1_tx_en_in,
  input  wire logic [LANES-1:0][L-1:0]   fs1_tx_dat_in,
  output logic      [LANES-1:0][W-1:0]   fs1_rdata_out,
  output logic      [LANES-1:0][L-1:0]   fs1_rx_out,
  // transceiver side, indexed by physical port
  input  wire logic [PORTS-1:0][L-1:0]   xcvr_rx_in,
  output logic      [PORTS-1:0]          xcvr_tx_en_out,
  output logic      [PORTS-1:0][L-1:0]   xcvr_tx_dat_out,
  output var upr_pkg::upr_speed_e [PORTS-1:0] xcvr_speed_out,
  output logic      [PORTS-1:0]          hs_owns_out
);
  typedef struct packed {
    logic             route_en;
    logic [PORTS-1:0] release_bits;
    logic [PORTS-1:0] owner_hs;
  } upr_route_s;

  upr_route_s st;
  upr_route_s next_st;

  // owner is registered so every lane switches on the same edge and no
  // lane ever sees a half-updated pair of ownership bits
  always_comb begin
    next_st = st;
    if (hs_route_wr_in) begin
      next_st.route_en = hs_route_in;
    end
    for (int p = 0; p < PORTS; p++) begin
      if (hs_release_wr_in[p]) begin
        next_st.release_bits[p] = hs_release_in[p];
      end
    end
    // with routing off every port falls back to its fs core
    next_st.owner_hs = {PORTS{next_st.route_en}} &
                       ~next_st.release_bits;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st.route_en     <= upr_pkg::ROUTE_RST;
      st.release_bits <= upr_pkg::RELEASE_RST[PORTS-1:0];
      st.owner_hs     <= upr_pkg::OWNER_NONE[PORTS-1:0];
    end else begin
      st <= next_st;
    end
  end

  assign hs_owns_out = st.owner_hs;

  // fixed fs wiring: even physical index to core 0, odd to core 1,
  // lane within the core is index / 2
  genvar p;
  generate
    for (p = 0; p < PORTS; p++) begin : g_port
      logic          fs_ls;
      logic          fs_wr;
      logic [W-1:0]  fs_wdata;
      logic          fs_tx_en;
      logic [L-1:0]  fs_tx_dat;
      logic [W-1:0]  fs_rdata;
      logic [L-1:0]  fs_rx;

      if ((p % 2) == 0) begin : g_core0
        assign fs_ls     = fs0_ls_in[p/2];
        assign fs_wr     = fs0_wr_in[p/2];
        assign fs_wdata  = fs0_wdata_in;
        assign fs_tx_en  = fs0_tx_en_in[p/2];
        assign fs_tx_dat = fs0_tx_dat_in[p/2];
        assign fs0_rdata_out[p/2] = fs_rdata;
        assign fs0_rx_out[p/2]    = fs_rx;
      end else begin : g_core1
        assign fs_ls     = fs1_ls_in[p/2];
        assign fs_wr     = fs1_wr_in[p/2];
        assign fs_wdata  = fs1_wdata_in;
        assign fs_tx_en  = fs1_tx_en_in[p/2];
        assign fs_tx_dat = fs1_tx_dat_in[p/2];
        assign fs1_rdata_out[p/2] = fs_rdata;
        assign fs1_rx_out[p/2]    = fs_rx;
      end

      upr_port_lane #(
        .W (W),
        .L (L)
      ) u_lane (
        .mclk_in         (mclk_in),
        .rst_n_in        (rst_n_in),
        .hs_own_in       (st.owner_hs[p]),
        .fs_ls_in        (fs_ls),
        .fs_wr_in        (fs_wr),
        .fs_wdata_in     (fs_wdata),
        .hs_wr_in        (hs_wr_in[p]),
        .hs_wdata_in     (hs_wdata_in),
        .fs_tx_en_in     (fs_tx_en),
        .fs_tx_dat_in    (fs_tx_dat),
        .hs_tx_en_in     (hs_tx_en_in[p]),
        .hs_tx_dat_in    (hs_tx_dat_in[p]),
        .xcvr_rx_in      (xcvr_rx_in[p]),
        .xcvr_tx_en_out  (xcvr_tx_en_out[p]),
        .xcvr_tx_dat_out (xcvr_tx_dat_out[p]),
        .xcvr_speed_out  (xcvr_speed_out[p]),
        .fs_rdata_out    (fs_rdata),
        .hs_rdata_out    (hs_rdata_out[p]),
        .fs_rx_out       (fs_rx),
        .hs_rx_out       (hs_rx_out[p])
      );
    end
  endgenerate

  // is the driver's duty; the router only obeys the bits it is given

  default clocking cb @(posedge mclk_in); endclocking

  sequence s_route_on;
    hs_route_wr_in && hs_route_in && (hs_release_wr_in == '0);
  endsequence

  sequence s_route_off;
    hs_route_wr_in && !hs_route_in;
  endsequence

  chk_reset_owner: assert property (
    !rst_n_in |-> hs_owns_out == '0)
    else $error("port owned by hs core during reset");

  chk_owner_grant: assert property (
    disable iff (!rst_n_in)
    s_route_on |=> hs_owns_out == ~$past(st.release_bits))
    else $error("route enable did not grant unreleased ports");

  chk_route_off_all: assert property (
    disable iff (!rst_n_in)
    s_route_off |=> hs_owns_out == '0 ##1
      ($past(hs_route_wr_in) || hs_owns_out == '0))
    else $error("routing off left a port with the hs core");

  chk_fixed_map_p3: assert property (
    disable iff (!rst_n_in)
    !st.owner_hs[2] |=> xcvr_tx_dat_out[2] == $past(fs0_tx_dat_in[1]))
    else $error("port 3 not fed by fs core 0 lane 1");

  chk_fixed_map_p2: assert property (
    disable iff (!rst_n_in)
    !st.owner_hs[1] |=> fs1_rx_out[0] == $past(xcvr_rx_in[1]))
    else $error("port 2 line state not returned to fs core 1");

  chk_switch_path: assert property (
    disable iff (!rst_n_in)
    $rose(st.owner_hs[0]) |-> ##1 (fs0_rx_out[0] == '0 &&
      xcvr_speed_out[0] == upr_pkg::SPD_HIGH))
    else $error("port 1 paths not moved to the hs core");
endmodule
`default_nettype wire

//--- common/upr_pkg.sv
// constants and types shared by the usb port ownership router
// assumes one clock domain, the host controller core clock
package upr_pkg;
  localparam int PORTS   = 4;
  localparam int LANES   = 2;
  localparam int LINE_W  = 2;
  localparam int PREG_W  = 8;
  // low nibble is the part both core kinds see; upper bits are high-speed only
  localparam logic [PREG_W-1:0] FS_VIS_MASK = 8'h0f;
  localparam logic [PREG_W-1:0] PREG_RST    = 8'h00;
  localparam logic [LINE_W-1:0] LINE_IDLE   = 2'h0;
  localparam logic              ROUTE_RST   = 1'h0;
  localparam logic [PORTS-1:0]  RELEASE_RST = 4'h0;
  localparam logic [PORTS-1:0]  OWNER_NONE  = 4'h0;
  // line rates: low 1.5 Mbit/s, full 12 Mbit/s, high 480 Mbit/s
  typedef enum logic [1:0] {SPD_LOW, SPD_FULL, SPD_HIGH} upr_speed_e;
endpackage

//--- rtl/upr_port_lane.sv
// one physical downstream port: register, transceiver mux, speed select
// assumes hs_own_in comes from a flop in the router and all inputs are
// synchronous to mclk_in
`timescale 1ns/1ps
`default_nettype none
module upr_port_lane #(
  parameter int W = upr_pkg::PREG_W,
  parameter int L = upr_pkg::LINE_W
) (
  input  wire logic          mclk_in,
  input  wire logic          rst_n_in,
  input  wire logic          hs_own_in,
  input  wire logic          fs_ls_in,
  input  wire logic          fs_wr_in,
  input  wire logic [W-1:0]  fs_wdata_in,
  input  wire logic          hs_wr_in,
  input  wire logic [W-1:0]  hs_wdata_in,
  input  wire logic          fs_tx_en_in,
  input  wire logic [L-1:0]  fs_tx_dat_in,
  input  wire logic          hs_tx_en_in,
  input  wire logic [L-1:0]  hs_tx_dat_in,
  input  wire logic [L-1:0]  xcvr_rx_in,
  output logic               xcvr_tx_en_out,
  output logic [L-1:0]       xcvr_tx_dat_out,
  output var upr_pkg::upr_speed_e xcvr_speed_out,
  output logic [W-1:0]       fs_rdata_out,
  output logic [W-1:0]       hs_rdata_out,
  output logic [L-1:0]       fs_rx_out,
  output logic [L-1:0]       hs_rx_out
);
  typedef struct packed {
    logic [W-1:0]        preg;
    logic                tx_en;
    logic [L-1:0]        tx_dat;
    upr_pkg::upr_speed_e speed;
    logic [L-1:0]        rx_fs;
    logic [L-1:0]        rx_hs;
  } upr_lane_s;

  upr_lane_s st;
  upr_lane_s next_st;

  always_comb begin
    next_st = st;
    // the non-owner's writes are dropped; fs may only touch shared bits
    if (hs_own_in) begin
      if (hs_wr_in) begin
        next_st.preg = hs_wdata_in;
      end
    end else if (fs_wr_in) begin
      next_st.preg = (st.preg & ~upr_pkg::FS_VIS_MASK[W-1:0]) |
                     (fs_wdata_in & upr_pkg::FS_VIS_MASK[W-1:0]);
    end
    // the non-owner sees quiet lines so it cannot mistake the other's traffic
    if (hs_own_in) begin
      next_st.tx_en  = hs_tx_en_in;
      next_st.tx_dat = hs_tx_dat_in;
      next_st.speed  = upr_pkg::SPD_HIGH;
      next_st.rx_hs  = xcvr_rx_in;
      next_st.rx_fs  = upr_pkg::LINE_IDLE[L-1:0];
    end else begin
      next_st.tx_en  = fs_tx_en_in;
      next_st.tx_dat = fs_tx_dat_in;
      next_st.speed  = fs_ls_in ? upr_pkg::SPD_LOW : upr_pkg::SPD_FULL;
      next_st.rx_fs  = xcvr_rx_in;
      next_st.rx_hs  = upr_pkg::LINE_IDLE[L-1:0];
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st.preg   <= upr_pkg::PREG_RST[W-1:0];
      st.tx_en  <= 1'b0;
      st.tx_dat <= upr_pkg::LINE_IDLE[L-1:0];
      st.speed  <= upr_pkg::SPD_FULL;
      st.rx_fs  <= upr_pkg::LINE_IDLE[L-1:0];
      st.rx_hs  <= upr_pkg::LINE_IDLE[L-1:0];
    end else begin
      st <= next_st;
    end
  end

  assign xcvr_tx_en_out  = st.tx_en;
  assign xcvr_tx_dat_out = st.tx_dat;
  assign xcvr_speed_out  = st.speed;
  assign fs_rdata_out    = st.preg & upr_pkg::FS_VIS_MASK[W-1:0];
  assign hs_rdata_out    = st.preg;
  assign fs_rx_out       = st.rx_fs;
  assign hs_rx_out       = st.rx_hs;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  // an fs write beside an hs write must not leak into the hs value either
  chk_fs_write_blocked: assert property (
    hs_own_in && fs_wr_in |=> st.preg ==
      ($past(hs_wr_in) ? $past(hs_wdata_in) : $past(st.preg)))
    else $error("fs write changed a port owned by the hs core");
  chk_fs_view_masked: assert property (
    (fs_rdata_out & ~upr_pkg::FS_VIS_MASK[W-1:0]) == '0)
    else $error("hs only bits visible to fs core");
  chk_hs_speed: assert property (
    hs_own_in |=> xcvr_speed_out == upr_pkg::SPD_HIGH)
    else $error("hs owned port not at high speed");
  chk_fs_speed: assert property (
    !hs_own_in |=> xcvr_speed_out ==
      ($past(fs_ls_in) ? upr_pkg::SPD_LOW : upr_pkg::SPD_FULL))
    else $error("fs owned port not at full or low speed");
  chk_tx_follows_owner: assert property (
    hs_own_in |=> xcvr_tx_dat_out == $past(hs_tx_dat_in) &&
                  xcvr_tx_en_out == $past(hs_tx_en_in) && fs_rx_out == '0)
    else $error("transceiver not switched to hs owner");
endmodule
`default_nettype wire

//--- tb/upr_xcvr_model.sv
// stand-in for the four port transceivers seen from the router
// assumes one clock; line state is never left stale between cycles
`timescale 1ns/1ps
`default_nettype none
module upr_xcvr_model (
  input  wire logic            mclk_in,
  input  wire logic            rst_n_in,
  input  wire logic [3:0]      tx_en_in,
  output logic      [3:0][1:0] rx_out
);
  logic [1:0] cnt;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 2'h0;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
  // a changing pattern, so a path stuck on an old value shows up
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      rx_out[p] = tx_en_in[p] ? ~cnt : cnt ^ 2'(p);
    end
  end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the usb port ownership router
// assumes upr_xcvr_model answers on the transceiver side
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("unexpected %s expected %h seen %h", n, e, g); \
  end \
end
module tb_top;
  logic            mclk_in = 1'b0, rst_n_in;
  logic            hs_route_wr_in = 1'b0, hs_route_in = 1'b0;
  logic [3:0]      hs_release_wr_in = 4'h0, hs_release_in = 4'h0;
  logic [3:0]      hs_wr_in = 4'h0, hs_tx_en_in = 4'h0;
  logic [3:0]      hs_owns_out, xcvr_tx_en_out;
  logic [7:0]      hs_wdata_in = 8'h00, fs0_wdata_in = 8'h00;
  logic [7:0]      fs1_wdata_in = 8'h00;
  logic [1:0]      fs0_wr_in = 2'h0, fs0_ls_in = 2'h0, fs0_tx_en_in = 2'h0;
  logic [1:0]      fs1_wr_in = 2'h0, fs1_ls_in = 2'h0, fs1_tx_en_in = 2'h0;
  logic [3:0][1:0] hs_tx_dat_in = 8'h00, hs_rx_out, xcvr_rx_in;
  logic [3:0][1:0] xcvr_tx_dat_out, rx_snap;
  logic [3:0][7:0] hs_rdata_out;
  logic [1:0][1:0] fs0_tx_dat_in = 4'h0, fs1_tx_dat_in = 4'h0;
  logic [1:0][1:0] fs0_rx_out, fs1_rx_out;
  logic [1:0][7:0] fs0_rdata_out, fs1_rdata_out;
  upr_pkg::upr_speed_e [3:0] xcvr_speed_out;
  int              fail_count = 0, samples_checked = 0;

  upr_router u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .hs_route_wr_in(hs_route_wr_in), .hs_route_in(hs_route_in),
    .hs_release_wr_in(hs_release_wr_in), .hs_release_in(hs_release_in),
    .hs_wr_in(hs_wr_in), .hs_wdata_in(hs_wdata_in),
    .hs_tx_en_in(hs_tx_en_in), .hs_tx_dat_in(hs_tx_dat_in),
    .hs_rdata_out(hs_rdata_out), .hs_rx_out(hs_rx_out),
    .fs0_wr_in(fs0_wr_in), .fs0_wdata_in(fs0_wdata_in),
    .fs0_ls_in(fs0_ls_in), .fs0_tx_en_in(fs0_tx_en_in),
    .fs0_tx_dat_in(fs0_tx_dat_in), .fs0_rdata_out(fs0_rdata_out),
    .fs0_rx_out(fs0_rx_out), .fs1_wr_in(fs1_wr_in),
    .fs1_wdata_in(fs1_wdata_in), .fs1_ls_in(fs1_ls_in),
    .fs1_tx_en_in(fs1_tx_en_in), .fs1_tx_dat_in(fs1_tx_dat_in),
    .fs1_rdata_out(fs1_rdata_out), .fs1_rx_out(fs1_rx_out),
    .xcvr_rx_in(xcvr_rx_in), .xcvr_tx_en_out(xcvr_tx_en_out),
    .xcvr_tx_dat_out(xcvr_tx_dat_out), .xcvr_speed_out(xcvr_speed_out),
    .hs_owns_out(hs_owns_out));
  upr_xcvr_model u_xcvr (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .tx_en_in(xcvr_tx_en_out), .rx_out(xcvr_rx_in));

  always #12.5 mclk_in = ~mclk_in;
  // line state the router saw at the last edge
  always @(posedge mclk_in) rx_snap <= xcvr_rx_in;

  task automatic give_verdict;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk_port(int p, logic hs);
    logic       ls, en;
    logic [1:0] d, r;
    ls = p % 2 ? fs1_ls_in[p/2] : fs0_ls_in[p/2];
    en = p % 2 ? fs1_tx_en_in[p/2] : fs0_tx_en_in[p/2];
    d = p % 2 ? fs1_tx_dat_in[p/2] : fs0_tx_dat_in[p/2];
    r = p % 2 ? fs1_rx_out[p/2] : fs0_rx_out[p/2];
    `CHK("tx", hs ? {hs_tx_en_in[p], hs_tx_dat_in[p]} : {en, d},
         {xcvr_tx_en_out[p], xcvr_tx_dat_out[p]})
    `CHK("speed", hs ? upr_pkg::SPD_HIGH : ls ? upr_pkg::SPD_LOW :
         upr_pkg::SPD_FULL, xcvr_speed_out[p])
    `CHK("fs_rx", hs ? 2'h0 : rx_snap[p], r)
    `CHK("hs_rx", hs ? rx_snap[p] : 2'h0, hs_rx_out[p])
  endtask

  task automatic t_fs_lanes;
    @(posedge mclk_in);
    fs0_ls_in <= 2'h1;
    fs1_ls_in <= 2'h2;
    fs0_tx_en_in <= 2'h3;
    fs1_tx_en_in <= 2'h1;
    fs0_tx_dat_in <= 4'h9;
    fs1_tx_dat_in <= 4'he;
    // hs values differ from fs values on every port
    hs_tx_en_in <= 4'h5;
    hs_tx_dat_in <= 8'h1e;
    repeat (3) @(posedge mclk_in);
    #1;
    for (int p = 0; p < 4; p++) chk_port(p, 1'b0);
  endtask

  task automatic t_hs_take;
    @(posedge mclk_in);
    hs_route_wr_in <= 1'b1;
    hs_route_in <= 1'b1;
    @(posedge mclk_in);
    hs_route_wr_in <= 1'b0;
    #1;
    `CHK("owns", 4'hf, hs_owns_out)
    repeat (2) @(posedge mclk_in);
    #1;
    for (int p = 0; p < 4; p++) chk_port(p, 1'b1);
    @(posedge mclk_in);
    hs_release_wr_in <= 4'h2;
    hs_release_in <= 4'h2;
    @(posedge mclk_in);
    hs_release_wr_in <= 4'h0;
    #1;
    `CHK("owns", 4'hd, hs_owns_out)
    repeat (2) @(posedge mclk_in);
    #1;
    for (int p = 0; p < 4; p++) chk_port(p, p != 1);
  endtask

  // both kinds of write land together on an hs port and an fs port
  task automatic t_regs;
    @(posedge mclk_in);
    fs0_wdata_in <= 8'hff;
    fs0_wr_in <= 2'h1;
    fs1_wdata_in <= 8'hff;
    fs1_wr_in <= 2'h1;
    hs_wdata_in <= 8'ha5;
    hs_wr_in <= 4'h3;
    @(posedge mclk_in);
    fs0_wr_in <= 2'h0;
    fs1_wr_in <= 2'h0;
    hs_wr_in <= 4'h0;
    @(posedge mclk_in);
    #1;
    `CHK("hs_rdata0", 8'ha5, hs_rdata_out[0])
    `CHK("fs0_rdata0", 8'h05, fs0_rdata_out[0])
    `CHK("hs_rdata1", 8'h0f, hs_rdata_out[1])
    `CHK("fs1_rdata0", 8'h0f, fs1_rdata_out[0])
  endtask

  // routing off hands every port back; fs writes then keep the hs only bits
  task automatic t_route_off;
    @(posedge mclk_in);
    hs_route_wr_in <= 1'b1;
    hs_route_in <= 1'b0;
    @(posedge mclk_in);
    hs_route_wr_in <= 1'b0;
    #1;
    `CHK("owns", 4'h0, hs_owns_out)
    @(posedge mclk_in);
    fs0_wdata_in <= 8'h3c;
    fs0_wr_in <= 2'h1;
    @(posedge mclk_in);
    fs0_wr_in <= 2'h0;
    #1;
    `CHK("hs_rdata0", 8'hac, hs_rdata_out[0])
    `CHK("fs0_rdata0", 8'h0c, fs0_rdata_out[0])
    for (int p = 0; p < 4; p++) chk_port(p, 1'b0);
    @(posedge mclk_in);
    hs_route_wr_in <= 1'b1;
    hs_route_in <= 1'b1;
    @(posedge mclk_in);
    hs_route_wr_in <= 1'b0;
    #1;
    `CHK("owns", 4'hd, hs_owns_out)
  endtask

  task automatic t_reset_state;
    for (int p = 0; p < 4; p++) begin
      `CHK("owns", 1'b0, hs_owns_out[p])
      `CHK("hs_rdata", 8'h00, hs_rdata_out[p])
      chk_port(p, 1'b0);
    end
  endtask

  initial begin
    // a real falling edge at time zero so every async reset branch runs
    rst_n_in <= 1'b0;
    repeat (16) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    #1;
    t_reset_state();
    t_fs_lanes();
    t_hs_take();
    t_regs();
    t_route_off();
    @(posedge mclk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    #1;
    t_reset_state();
    give_verdict();
  end

  // whole run is well under 100 cycles
  initial begin
    repeat (2000) @(posedge mclk_in);
    fail_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
